//--- shared/dtc_map.svh
// Constants of the disk transfer control block
`ifndef DTC_MAP_SVH
`define DTC_MAP_SVH
`define DTC_CLK_PERIOD_NS   4
`define DTC_ERASE_DELAY_NS  200
`define DTC_ERASE_DELAY_CYC ((`DTC_ERASE_DELAY_NS + `DTC_CLK_PERIOD_NS - 1) / `DTC_CLK_PERIOD_NS)
`define DTC_DLY_W           6
`define DTC_HEADS           4
`define DTC_PINS            23
`define DTC_PIN_IDLE        23'h7FC000
`define DTC_FLT_ERASE       0
`define DTC_FLT_DC          1
`define DTC_FLT_AC          2
`define DTC_FLT_HEAD        3
`define DTC_FLT_W           4
`endif

//--- shared/dtc_pkg.sv
// Types of the disk transfer control block
package dtc_pkg;
    typedef logic [3:0] dtc_heads_t;      // One-hot active-low head selects
    typedef logic [3:0] dtc_faults_t;     // Fault identification flags
    typedef enum logic [1:0] {DTC_IDLE, DTC_WAIT, DTC_TRIP} dtc_erase_e;
endpackage

//--- src/dtc_core.sv
// Disk transfer control: head select, mode gating, protect, write driver, faults
`timescale 1ns/1ps
`include "dtc_map.svh"

module dtc_core
(
    input  wire logic               i_clk,               // 250 MHz clock
    input  wire logic               i_rst_b,             // Async reset, active low
    input  wire logic               i_disk_choice_n,     // Disk choice pin
    input  wire logic               i_surface_choice_n,  // Head choice pin
    input  wire logic               i_unit_chosen_n,     // Drive selected pin
    input  wire logic               i_read_gate_n,       // Read gate pin
    input  wire logic               i_write_gate_n,      // Write gate pin
    input  wire logic               i_erase_gate_n,      // Erase gate pin
    input  wire logic               i_host_protect_req_n,// Host protect request
    input  wire logic               i_write_data_n,      // Write data pulses
    input  wire logic               i_inner_track_zone_n,// Inner tracks
    input  wire logic               i_top_disk,          // Top disk addressed
    input  wire logic               i_erase_source_option,  // Closed = erase gate
    input  wire logic               i_upper_protect_option, // Closed = no protect
    input  wire logic               i_lower_protect_option, // Closed = no protect
    input  wire logic               i_panel_unprotect,   // Protect pushbutton
    input  wire logic               i_emergency_retract, // Retract event level
    input  wire logic               i_load_mode,         // High in load mode
    input  wire logic               i_indicator_set,     // Sets lamp latch
    input  wire logic               i_erase_current,     // Erase current sensed
    input  wire logic               i_dc_current,        // DC write current sensed
    input  wire logic               i_ac_missing,        // AC sense output high
    input  wire logic               i_multi_head_wr,     // Write-side comparator
    input  wire logic               i_multi_head_rd,     // Read-side comparator
    input  wire logic               i_fault_clear,       // Re-arms flags and check
    output logic                    o_head_sel_n [`DTC_HEADS],  // Head selects
    output logic                    o_separator_en,      // Separator output enable
    output logic                    o_internal_write_cmd_n, // To fault detection
    output logic                    o_write_bias_en_n,   // Write bias enable
    output logic                    o_read_clamp_n,      // Read amp clamp
    output logic                    o_write_drive,       // Write driver enable
    output logic                    o_erase_drive,       // Erase coil drive
    output logic                    o_erase_cmd_flag,    // Erase command flag
    output logic                    o_coil_a,            // Coil half A
    output logic                    o_coil_b,            // Coil half B
    output logic                    o_current_reduce,    // Shunt write current
    output logic                    o_protected_status_n,// Protect status
    output logic                    o_protect_lamp,      // Protect light
    output logic                    o_write_check_cond_n,// Write check, low = set
    output logic                    o_dc_fault_probe,    // Low on DC fault
    output logic                    o_ac_fault_probe,    // Low on AC fault
    output dtc_pkg::dtc_faults_t    o_fault_flags        // Fault identification
);
    import dtc_pkg::*;

    // Pin sampler: two flops per pin, stage one read only by stage two
    localparam int NPIN = `DTC_PINS;
    logic [NPIN-1:0] pin_raw;   // Raw pins
    logic [NPIN-1:0] pin_s1;    // First stage
    logic [NPIN-1:0] pin_s2;    // Synchronised pins
    assign pin_raw = {i_disk_choice_n, i_surface_choice_n, i_unit_chosen_n,
                      i_read_gate_n, i_write_gate_n, i_erase_gate_n,
                      i_host_protect_req_n, i_write_data_n, i_inner_track_zone_n,
                      i_top_disk, i_erase_source_option, i_upper_protect_option,
                      i_lower_protect_option, i_panel_unprotect, i_emergency_retract,
                      i_load_mode, i_indicator_set, i_erase_current, i_dc_current,
                      i_ac_missing, i_multi_head_wr, i_multi_head_rd, i_fault_clear};

    // Two-flop synchroniser; reset loads each pin's idle level so that
    // no edge detector sees a false edge as reset lets go
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            pin_s1 <= `DTC_PIN_IDLE;
            pin_s2 <= `DTC_PIN_IDLE;
        end
        else
        begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
        end
    end

    // Synchronised pins, split out by role
    logic disk_n, surf_n, unit_n, rgate_n, wgate_n, egate_n, hreq_n, wdata_n;
    logic inner_n, top, eopt, uopt, lopt, unprot, retract, loadm, ind_set;
    logic ecur, dccur, acmiss, mh_wr, mh_rd, fclr;
    assign {disk_n, surf_n, unit_n, rgate_n, wgate_n, egate_n, hreq_n, wdata_n,
            inner_n, top, eopt, uopt, lopt, unprot, retract, loadm, ind_set,
            ecur, dccur, acmiss, mh_wr, mh_rd, fclr} = pin_s2;

    // Decode of a two-bit head number into active-low one-hot
    // A set disable input keeps every select high
    function automatic dtc_heads_t dtc_decode(input logic [1:0] num, input logic dis);
        dtc_heads_t v;
        v = 4'hF;
        if (!dis)
            v[num] = 1'b0;
        return v;
    endfunction

    logic write_protect_n;  // Combined protect, low = protected
    logic sel_inhibit;      // Decoder disable
    dtc_heads_t heads_n;    // Next head selects
    // Decoder disables: deselected, or protect outside read
    assign sel_inhibit = unit_n
                       || (!write_protect_n && (unit_n || rgate_n));
    assign heads_n = dtc_decode({disk_n, surf_n}, sel_inhibit);

    // Mode gating
    logic wr_cmd;    // Internal write command, high = active
    logic erase_src; // Erase before protect gate
    logic erase_on;  // Gated erase
    assign wr_cmd    = !wgate_n && !unit_n && write_protect_n;
    assign erase_src = eopt ? !egate_n : (!wgate_n && !unit_n);
    assign erase_on  = erase_src && write_protect_n;

    // Registered mode outputs
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_separator_en         <= 1'b0;
            o_internal_write_cmd_n <= 1'b1;
            o_write_bias_en_n      <= 1'b1;
            o_read_clamp_n         <= 1'b1;
            o_write_drive          <= 1'b0;
            o_erase_drive          <= 1'b0;
            o_erase_cmd_flag       <= 1'b0;
            o_current_reduce       <= 1'b0;
            for (int h = 0; h < `DTC_HEADS; h++)
                o_head_sel_n[h] <= 1'b1;
        end
        else
        begin
            o_separator_en         <= !rgate_n;
            o_internal_write_cmd_n <= !wr_cmd;
            o_write_bias_en_n      <= !wr_cmd;
            o_read_clamp_n         <= !wr_cmd;
            o_write_drive          <= wr_cmd;
            o_erase_drive          <= erase_on;
            o_erase_cmd_flag       <= erase_on;
            o_current_reduce       <= !inner_n;
            for (int h = 0; h < `DTC_HEADS; h++)
                o_head_sel_n[h] <= heads_n[h];
        end
    end

    // Clear pulse: reset release, retract, run to load
    logic boot_done, retract_d, load_d, clear_pulse_n;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            boot_done <= 1'b0;
            retract_d <= 1'b0;
            load_d    <= 1'b1;
        end
        else
        begin
            boot_done <= 1'b1;
            retract_d <= retract;
            load_d    <= loadm;
        end
    end
    assign clear_pulse_n = !(!boot_done || (retract && !retract_d)
                             || (loadm && !load_d));

    // Protect latches, upper index 1, lower index 0
    logic [1:0] prot;      // Latch states
    logic [1:0] prot_opt;  // Option switch closed
    assign prot_opt = {uopt, lopt};
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_prot
            // Set by clear pulse or host; cleared by panel; option closed holds off
            always_ff @(posedge i_clk or negedge i_rst_b)
            begin
                if (!i_rst_b)
                    prot[g] <= 1'b0;
                else if (prot_opt[g])
                    prot[g] <= 1'b0;
                else if (unprot)
                    prot[g] <= 1'b0;
                else if (!clear_pulse_n || !hreq_n)
                    prot[g] <= 1'b1;
            end
        end
    endgenerate

    // Qualified disk latches and the write check merge into one protect level
    logic write_check;  // Write check condition, high = set
    assign write_protect_n = !((prot[1] && top) || (prot[0] && !top)
                               || write_check);

    // Status and lamp
    logic lamp;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            o_protected_status_n <= 1'b1;
            lamp                 <= 1'b0;
        end
        else
        begin
            o_protected_status_n <= !(!unit_n && (|prot));
            if (ind_set)
                lamp <= 1'b1;
            else if (!(|prot))
                lamp <= 1'b0;
        end
    end
    assign o_protect_lamp = lamp;

    // Write toggle on falling edge of write data while selected
    logic wdata_d, toggle;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wdata_d <= 1'b1;
            toggle  <= 1'b0;
        end
        else
        begin
            wdata_d <= wdata_n;
            if (!unit_n && !wdata_n && wdata_d)
                toggle <= !toggle;
        end
    end
    // Coil halves are always complementary
    assign o_coil_a = toggle;
    assign o_coil_b = !toggle;

    // Fault detectors, each high while its fault stands
    // Detector outputs are levels; latching happens further down
    logic erase_fault, dc_fault, ac_fault, head_fault;
    assign erase_fault = ecur != erase_on;
    assign dc_fault    = wr_cmd && !dccur;
    assign ac_fault    = wr_cmd && (acmiss || !dccur);
    assign head_fault  = wr_cmd ? mh_wr : (!rgate_n && mh_rd);

    // Erase fault delay: must persist for the delay before tripping
    dtc_erase_e er_state;
    logic [`DTC_DLY_W-1:0] er_cnt;
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            er_state <= DTC_IDLE;
            er_cnt   <= '0;
        end
        else
        begin
            case (er_state)
                DTC_IDLE:
                begin
                    er_cnt <= '0;
                    if (erase_fault)
                        er_state <= DTC_WAIT;
                end
                DTC_WAIT:
                begin
                    if (!erase_fault)
                        er_state <= DTC_IDLE;
                    else if (er_cnt == `DTC_DLY_W'(`DTC_ERASE_DELAY_CYC - 1))
                        er_state <= DTC_TRIP;
                    else
                        er_cnt <= er_cnt + 1'b1;
                end
                DTC_TRIP:
                    if (!erase_fault)
                        er_state <= DTC_IDLE;
                default:
                    er_state <= DTC_IDLE;
            endcase
        end
    end

    // Fault flags and write check; setting wins over clearing
    dtc_faults_t flags;
    logic [`DTC_FLT_W-1:0] fset;
    // Collect the detector outputs by flag position
    always_comb
    begin
        fset = '0;
        fset[`DTC_FLT_ERASE] = erase_fault;
        fset[`DTC_FLT_DC]    = dc_fault;
        fset[`DTC_FLT_AC]    = ac_fault;
        fset[`DTC_FLT_HEAD]  = head_fault;
    end
    always_ff @(posedge i_clk or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            flags       <= '0;
            write_check <= 1'b0;
        end
        else
        begin
            flags <= fset | (fclr ? '0 : flags);
            if ((er_state == DTC_TRIP) || dc_fault || ac_fault || head_fault)
                write_check <= 1'b1;
            else if (fclr)
                write_check <= 1'b0;
        end
    end
    // Outputs: flags as kept, probes low on their fault
    assign o_fault_flags        = flags;
    assign o_write_check_cond_n = !write_check;
    assign o_dc_fault_probe     = !flags[`DTC_FLT_DC];
    assign o_ac_fault_probe     = !flags[`DTC_FLT_AC];

    // Assertions
    // A write command that finds no DC current
    sequence s_wcmd; wr_cmd && !dccur; endsequence
    // An erase detector output that lasts one sample only
    sequence s_erase_blip; !erase_fault ##1 erase_fault ##1 !erase_fault; endsequence
    // DC loss raises both probes and the check at the next edge
    a_dc_check_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_wcmd |=> write_check && !o_dc_fault_probe && !o_ac_fault_probe)
        else $error("dc fault not latched");
    // Partial AC loss raises its probe and the check
    a_ac_check_set: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        wr_cmd && acmiss |=> write_check && !o_ac_fault_probe)
        else $error("ac fault not latched");
    // A one-sample erase fault never reaches the trip state
    a_erase_glitch_ignored: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        s_erase_blip |-> er_state != DTC_TRIP)
        else $error("erase glitch tripped");
    // Deselection releases every head select one edge later
    a_deselect_no_head: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        unit_n |=> (o_head_sel_n[0] && o_head_sel_n[1] && o_head_sel_n[2]
                    && o_head_sel_n[3]))
        else $error("head selected while deselected");
    // A standing write check stops write and erase
    a_check_blocks_write: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        write_check |=> o_internal_write_cmd_n && !o_erase_drive)
        else $error("write during write check");
    // Selected with the upper disk protected pulls status low
    a_status_follows: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !unit_n && prot[1] |=> !o_protected_status_n)
        else $error("status not low");
    // A closed option keeps the upper latch clear
    a_option_unprot: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        uopt |=> !prot[1])
        else $error("upper protected with option closed");
    // A write data edge while selected flips the coil halves
    a_write_toggle: assert property (@(posedge i_clk) disable iff (!i_rst_b)
        !unit_n && !wdata_n && wdata_d |=> toggle != $past(toggle))
        else $error("write flop did not toggle");
endmodule

//--- dv/dtc_host_model.sv
// Host controller model that drives the drive interface lines
`timescale 1ns/1ps
module dtc_host_model
(
    input  wire logic i_clk,                // Bench clock
    output logic      o_disk_choice_n,      // Head number, upper bit
    output logic      o_surface_choice_n,   // Head number, lower bit
    output logic      o_unit_chosen_n,      // Drive select
    output logic      o_read_gate_n,        // Read request
    output logic      o_write_gate_n,       // Write request
    output logic      o_erase_gate_n,       // Erase request
    output logic      o_host_protect_req_n, // Protect request
    output logic      o_write_data_n        // Write data pulses
);
    // Every line idles high
    initial
    begin
        {o_disk_choice_n, o_surface_choice_n, o_unit_chosen_n, o_read_gate_n} = 4'hF;
        {o_write_gate_n, o_erase_gate_n, o_host_protect_req_n, o_write_data_n} = 4'hF;
    end
    // Levels {unit, read, write, erase, protect} change just after an edge
    task automatic lines(input logic [1:0] hd, input logic [4:0] ctl);
        @(posedge i_clk);
        {o_disk_choice_n, o_surface_choice_n} <= hd;
        {o_unit_chosen_n, o_read_gate_n, o_write_gate_n} <= ctl[4:2];
        o_erase_gate_n       <= ctl[1];
        o_host_protect_req_n <= ctl[0];
    endtask
    // Data pulses, three cycles low then three high
    task automatic pulse(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            o_write_data_n <= 1'b0;
            repeat (3) @(posedge i_clk);
            o_write_data_n <= 1'b1;
            repeat (2) @(posedge i_clk);
        end
    endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench of the disk transfer control block
`timescale 1ns/1ps
`define CMP(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("wrong value %s expected %h seen %h", n, e, g); end end
module tb_top;
    import dtc_pkg::*;
    typedef struct {string nm; int lo; int w; logic [7:0] e;} dtc_note_s;
    localparam int SEP = 4, WCMD = 5, BIAS = 6, CLMP = 7, WDRV = 8, EDRV = 9, EFLG = 10;
    localparam int RED = 11, STAT = 12, LAMP = 13, WCHK = 14, DCP = 15, FLG = 17, CA = 21;
    localparam logic [4:0] OFF = 5'h1F, SEL = 5'h0F, RD = 5'h07, WR = 5'h0B, ER = 5'h0D;
    localparam logic [4:0] PR = 5'h0E;
    localparam logic [3:0] STIM [4] = '{4'h0, 4'hC, 4'hA, 4'h1}; // Sense inputs per fault
    localparam logic [7:0] FLT [4] = '{8'h03, 8'h02, 8'h04, 8'h04}; // Head, AC, DC flags
    localparam logic [7:0] PRB [4] = '{8'h00, 8'h01, 8'h03, 8'h03}; // AC and DC probes
    // Design inputs, named as the ports
    logic i_clk, i_rst_b, i_top_disk, i_erase_source_option, i_upper_protect_option;
    logic i_lower_protect_option, i_inner_track_zone_n, i_erase_current, i_dc_current;
    logic i_ac_missing, i_multi_head_wr, i_multi_head_rd;
    wire logic i_disk_choice_n, i_surface_choice_n, i_unit_chosen_n, i_read_gate_n;
    wire logic i_write_gate_n, i_erase_gate_n, i_host_protect_req_n, i_write_data_n;
    wire logic i_panel_unprotect, i_emergency_retract, i_load_mode, i_indicator_set;
    wire logic i_fault_clear;
    // Design outputs
    logic o_head_sel_n [4];
    logic o_separator_en, o_internal_write_cmd_n, o_write_bias_en_n, o_read_clamp_n;
    logic o_write_drive, o_erase_drive, o_erase_cmd_flag, o_coil_a, o_coil_b;
    logic o_current_reduce, o_protected_status_n, o_protect_lamp, o_write_check_cond_n;
    logic o_dc_fault_probe, o_ac_fault_probe;
    dtc_faults_t o_fault_flags;
    // Bench state
    logic [4:0]  ev;         // Clear, indicator, load, retract, button
    logic [22:0] obs;        // All outputs packed
    logic        ebad;       // Forces a wrong erase sense
    logic        chk_go;     // Compare strobe
    logic [7:0]  got;        // Observed field
    logic [31:0] seed;       // Random state
    dtc_note_s   nt;         // Note under compare
    dtc_note_s   notes [$];  // Expected results
    int          num_errors, n_compared, tog, n;
    assign {i_fault_clear, i_indicator_set, i_load_mode, i_emergency_retract,
            i_panel_unprotect} = ev;
    assign obs = {o_coil_b, o_coil_a, o_fault_flags, o_ac_fault_probe, o_dc_fault_probe,
                  o_write_check_cond_n, o_protect_lamp, o_protected_status_n,
                  o_current_reduce, o_erase_cmd_flag, o_erase_drive, o_write_drive,
                  o_read_clamp_n, o_write_bias_en_n, o_internal_write_cmd_n,
                  o_separator_en, o_head_sel_n[3], o_head_sel_n[2], o_head_sel_n[1],
                  o_head_sel_n[0]};
    dtc_core dut (.*);
    dtc_host_model host (.i_clk(i_clk), .o_disk_choice_n(i_disk_choice_n),
        .o_surface_choice_n(i_surface_choice_n), .o_unit_chosen_n(i_unit_chosen_n),
        .o_read_gate_n(i_read_gate_n), .o_write_gate_n(i_write_gate_n),
        .o_erase_gate_n(i_erase_gate_n), .o_host_protect_req_n(i_host_protect_req_n),
        .o_write_data_n(i_write_data_n));
    // Clock at 4 ns
    initial
    begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    // Erase sense follows the coil drive unless forced wrong
    always @(posedge i_clk)
        i_erase_current <= o_erase_drive ^ ebad;
    // Watcher takes the oldest notes and compares
    always @(negedge i_clk)
    begin
        while (chk_go && notes.size() > 0)
        begin
            nt = notes.pop_front();
            got = 8'((obs >> nt.lo) & ((23'h1 << nt.w) - 23'h1));
            `CMP(nt.nm, nt.e, got)
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] v);
        v ^= v << 13;
        v ^= v >> 17;
        v ^= v << 5;
        return v;
    endfunction
    task automatic ex(input string nm, input int lo, input int w, input logic [7:0] e);
        notes.push_back('{nm, lo, w, e});
    endtask
    task automatic check_now();
        @(posedge i_clk);
        chk_go <= 1'b1;
        @(posedge i_clk);
        chk_go <= 1'b0;
    endtask
    task automatic settle();
        repeat (5) @(posedge i_clk);
    endtask
    // One event level high for a while, then low again
    task automatic blip(input int k);
        ev[k] <= 1'b1;
        settle();
        ev[k] <= 1'b0;
        settle();
    endtask
    task automatic end_test(input string nm);
        check_now();
        $display("test %s done", nm);
    endtask
    task automatic finish_test();
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    initial
    begin
        repeat (30000) @(posedge i_clk);
        num_errors++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        {i_rst_b, i_top_disk, i_erase_source_option, i_upper_protect_option} = 4'h0;
        {i_lower_protect_option, i_dc_current, i_ac_missing, i_multi_head_wr} = 4'h0;
        {i_multi_head_rd, i_erase_current, ebad, chk_go} = 4'h0;
        i_inner_track_zone_n = 1'b1;
        ev = 5'h00;
        seed = 32'h000141BD;
        tog = 0;
        repeat (6) @(posedge i_clk);
        i_rst_b <= 1'b1;
        // Disks come up protected
        host.lines(2'h0, SEL);
        settle();
        ex("status", STAT, 1, 8'h00);
        ex("heads", 0, 4, 8'h0F);
        check_now();
        host.lines(2'h0, RD);
        settle();
        ex("heads", 0, 4, 8'h0E);
        ex("separator", SEP, 1, 8'h01);
        end_test("protect at reset");
        // Button clears, then every head decodes
        blip(0);
        for (int h = 0; h < 4; h++)
        begin
            host.lines(2'(h), SEL);
            settle();
            ex("heads", 0, 4, 8'h0F ^ (8'h01 << h));
            check_now();
        end
        ex("status", STAT, 1, 8'h01);
        ex("separator", SEP, 1, 8'h00);
        ex("lamp", LAMP, 1, 8'h00);
        check_now();
        host.lines(2'h0, OFF);
        settle();
        ex("heads", 0, 4, 8'h0F);
        end_test("head decode");
        // Upper disk protected by request, lower option closed
        i_lower_protect_option <= 1'b1;
        i_top_disk <= 1'b1;
        host.lines(2'h0, PR);
        host.lines(2'h0, SEL);
        settle();
        ex("status", STAT, 1, 8'h00);
        blip(3);
        ex("lamp", LAMP, 1, 8'h01);
        check_now();
        i_top_disk <= 1'b0;
        i_dc_current <= 1'b1;
        host.lines(2'h0, WR);
        settle();
        ex("status", STAT, 1, 8'h00);
        ex("write cmd", WCMD, 1, 8'h00);
        ex("bias clamp", BIAS, 2, 8'h00);
        ex("write drive", WDRV, 1, 8'h01);
        ex("erase", EDRV, 2, 8'h03);
        check_now();
        i_top_disk <= 1'b1;
        settle();
        ex("write cmd", WCMD, 1, 8'h01);
        ex("erase", EDRV, 2, 8'h00);
        check_now();
        host.lines(2'h0, SEL);
        i_dc_current <= 1'b0;
        i_lower_protect_option <= 1'b0;
        blip(0);
        ex("lamp", LAMP, 1, 8'h00);
        end_test("protect options");
        // Erase taken from erase gate alone
        i_erase_source_option <= 1'b1;
        host.lines(2'h0, ER);
        settle();
        ex("erase", EDRV, 2, 8'h03);
        ex("write drive", WDRV, 1, 8'h00);
        check_now();
        i_dc_current <= 1'b1;
        host.lines(2'h0, WR);
        i_inner_track_zone_n <= 1'b0;
        settle();
        ex("erase", EDRV, 2, 8'h00);
        ex("reduce", RED, 1, 8'h01);
        check_now();
        i_inner_track_zone_n <= 1'b1;
        settle();
        ex("reduce", RED, 1, 8'h00);
        i_erase_source_option <= 1'b0;
        end_test("erase source");
        // Coil halves swap on each data pulse while selected
        for (int r = 0; r < 3; r++)
        begin
            seed = xs(seed);
            n = int'(seed[2:0]) + 1;
            host.lines(2'h0, (r == 2) ? OFF : WR);
            host.pulse(n);
            tog += (r == 2) ? 0 : n;
            settle();
            ex("coils", CA, 2, (tog % 2 == 1) ? 8'h01 : 8'h02);
            check_now();
        end
        host.lines(2'h0, SEL);
        i_dc_current <= 1'b0;
        end_test("write driver");
        // DC, AC and head faults, each cleared after
        blip(4);
        for (int k = 0; k < 4; k++)
        begin
            {i_dc_current, i_ac_missing, i_multi_head_wr, i_multi_head_rd} <= STIM[k];
            host.lines(2'h0, (k == 3) ? RD : WR);
            settle();
            ex("flags", FLG + 1, 3, FLT[k]);
            ex("probes", DCP, 2, PRB[k]);
            ex("check", WCHK, 1, 8'h00);
            ex("write drive", WDRV, 1, 8'h00);
            ex("status", STAT, 1, 8'h01);
            ex("erase", EDRV, 2, 8'h00);
            check_now();
            host.lines(2'h0, SEL);
            {i_dc_current, i_ac_missing, i_multi_head_wr, i_multi_head_rd} <= 4'h0;
            blip(4);
        end
        // Short erase glitch flags only, a long one trips the check
        ebad <= 1'b1;
        repeat (10) @(posedge i_clk);
        ebad <= 1'b0;
        settle();
        ex("erase flag", FLG, 1, 8'h01);
        ex("check", WCHK, 1, 8'h01);
        check_now();
        blip(4);
        ebad <= 1'b1;
        repeat (70) @(posedge i_clk);
        ex("check", WCHK, 1, 8'h00);
        check_now();
        ebad <= 1'b0;
        blip(4);
        end_test("faults");
        // Retract and run-to-load set the latches
        for (int k = 1; k < 3; k++)
        begin
            blip(0);
            ex("status", STAT, 1, 8'h01);
            check_now();
            blip(k);
            ex("status", STAT, 1, 8'h00);
            check_now();
        end
        end_test("events");
        finish_test();
    end
endmodule
